// ### pkg/bast_defs.svh
`ifndef BAST_DEFS_SVH
`define BAST_DEFS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_STATUS 8'h64
`define OFS_RESET_TEST 8'h7A
`define OFS_BUF_ACCESS 8'h70
`define OFS_BUF_AUTOINC 8'h72
`define OFS_DATA_LATCH 8'hE8
`define OFS_PTR_LO 8'hEC
`define OFS_PTR_MID 8'hEA
`define OFS_PTR_HI 8'hEE
`define OFS_TEST_VIEW 8'hF8
// ----------------------------------------
// status bits
// ----------------------------------------
`define ST_PARITY 2
`define ST_BUF_PEND 3
`define ST_RST_PEND 4
`define ST_DEV_NR 7
// ----------------------------------------
// reset and test bits
// ----------------------------------------
`define RT_FIFO_A 0
`define RT_FIFO_B 1
`define RT_CNT_TEST 2
`define RT_MEM_FLOAT 3
`define RT_CHAN_A 4
`define RT_CHAN_B 5
`define RT_SW_RESET 7
`define RT_RESET_VAL 8'h00
`define RT_TEST_MASK 8'h3F
// ----------------------------------------
// unlock codes and timing
// ----------------------------------------
`define UNLOCK_FIRST 8'h80
`define UNLOCK_SECOND 8'hF0
`define RESET_SEQ_NS 1600
`define CLOCK_NS 100
`define RESET_SEQ_CYCLES ((`RESET_SEQ_NS + `CLOCK_NS - 1) / `CLOCK_NS)
`endif

// ### pkg/bast_pkg.sv
`default_nettype none
package bast_pkg;
    // buffer access engine
    typedef enum logic [1:0] {
        BA_IDLE = 2'b00,
        BA_WAIT = 2'b01,
        BA_DONE = 2'b10
    } ba_state_t;
    // unlock interlock
    typedef enum logic [1:0] {
        UL_IDLE = 2'b00,
        UL_ARMED = 2'b01,
        UL_SET = 2'b10,
        UL_OPEN = 2'b11
    } ul_state_t;
endpackage
`default_nettype wire

// ### hdl/buffer_access_status_test.sv
`include "bast_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module buffer_access_status_test #(
    parameter int RESET_CYCLES = `RESET_SEQ_CYCLES, // reset sequence length
    parameter int PTR_W = 20 // buffer pointer width
) (
    input wire logic clock, // 10 MHz clock
    input wire logic channel_a_reset_bit_n, // async reset, active low
    input wire logic [7:0] address, // avalon byte address
    input wire logic read, // avalon read
    input wire logic write, // avalon write
    input wire logic [31:0] writedata, // avalon write data
    input wire logic [3:0] byteenable, // avalon byte enables
    output logic [31:0] readdata, // avalon read data
    output logic waitrequest, // avalon wait
    output logic [PTR_W-1:0] mem_address, // buffer address
    output logic [7:0] mem_wdata, // buffer write data
    output logic mem_write, // buffer cycle is a write
    output logic mem_req, // buffer cycle request
    input wire logic mem_ack, // buffer cycle done (pulse)
    input wire logic [7:0] mem_rdata, // buffer read data
    input wire logic mem_parity_err, // parity error with mem_ack
    output logic route_fifo_a, // buffer path to fifo A
    output logic route_fifo_b, // buffer path to fifo B
    output logic counter_test, // nibble counter mode for other counters
    output logic mem_ctrl_oe_n, // memory controls float when high
    output logic channel_a_reset, // hold channel A in reset
    output logic channel_b_reset, // hold channel B in reset
    output logic full_reset, // reset sequence running
    input wire logic pio_busy, // programmed i/o access pending
    input wire logic [7:0] test_probe // extra view from selected channel logic
);
    import bast_pkg::*;

    // ----------------------------------------
    // bus behaviour
    // ----------------------------------------
    // one access is taken on each edge with waitrequest low
    // a new request may follow right after the accept edge
    // read data is shown during the accept cycle itself
    // so the master takes it at the same edge it sees ready
    // the view is a mux of registered state plus the pio_busy and test_probe inputs, no new logic depth
    // side effects of a read (fetch start) land at that edge
    // only the status location answers during a reset sequence
    // buffer windows stall while an earlier buffer cycle runs
    // latch and pointer locations never stall outside reset
    // limitation: pointer writes during a buffer cycle are not
    // blocked; firmware must wait for the pending bit to clear
    // unmapped locations read zero and ignore writes

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] rst_test; // reset and test register
        logic parity_flag; // cpu parity error flag
        ba_state_t ba; // buffer access engine
        logic ba_incr; // access came via autoincrement
        logic ba_is_write; // access direction
        logic [7:0] latch; // buffer data latch
        logic [PTR_W-1:0] ptr; // buffer address pointer
        logic [7:0] tsel; // test select register
        ul_state_t ul; // unlock interlock
        logic test_on; // test mode active
        logic [15:0] rst_cnt; // reset sequence counter
        logic rst_run; // reset sequence running
        logic sw_pend; // software reset armed by write
        logic [31:0] rdata; // read data
    } state_t;

    // all state lives in one struct so that reset and the
    // next-state copy stay in step; a field added here is
    // reset with everything else by the all-zero default
    // the trade-off is a wide register that a synthesis
    // tool may not share across unrelated fields
    state_t cur; // registered state
    state_t next_s; // next state

    logic wr_hit; // write taken this cycle
    logic rd_hit; // read taken this cycle
    logic [7:0] wbyte; // low write byte
    logic pending; // buffer pending bit
    logic dev_nr; // device not ready bit
    logic [7:0] status_byte; // master status view
    logic [7:0] eff_test; // test bits after interlock

    // nibble-split increment for counter test
    // in normal mode the carry ripples through all bits
    // in test mode every nibble counts on its own, with its
    // carry in forced true, so one step touches every nibble
    // this lets a tester reach each nibble's carry out quickly
    function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] v, input logic split);
        logic [PTR_W-1:0] r;
        r = v + PTR_W'(1);
        if (split) begin
            for (int i = 0; i < PTR_W / 4; i++) begin
                r[i*4 +: 4] = v[i*4 +: 4] + 4'h1;
            end
        end
        return r;
    endfunction

    // ----------------------------------------
    // combinational decode
    // ----------------------------------------
    // the bus is byte wide in use; the upper lanes are ignored
    // status is built live so firmware sees every flag at once
    // not ready is the or of all busy sources, never a copy
    // held in a flop, so it drops in the cycle the last one ends
    // programmed i/o busy comes from channel logic outside
    // test bits act only after the unlock, so a stray write
    // of the reset and test register cannot float memory
    always_comb begin
        wbyte = writedata[7:0];
        wr_hit = write;
        rd_hit = read;
        pending = (cur.ba != BA_IDLE);
        // test bits only count once the interlock is open
        eff_test = cur.test_on ? (cur.rst_test & `RT_TEST_MASK) : 8'h00;
        dev_nr = cur.rst_run || pending || pio_busy;
        status_byte = 8'h00;
        status_byte[`ST_PARITY] = cur.parity_flag;
        status_byte[`ST_BUF_PEND] = pending;
        status_byte[`ST_RST_PEND] = cur.rst_run;
        status_byte[`ST_DEV_NR] = dev_nr;
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    // order matters below: the reset sequence first, then the
    // software reset launch, then the buffer engine and last
    // the bus, so that a bus write can override engine results
    // the parity clear checks for a same-cycle set and lets the
    // set win, so an error is never lost to a racing clear
    // the software reset waits for the strobe to fall, so the
    // writing access finishes before the registers are cleared
    // a read of the buffer windows returns the latch and starts
    // the next fetch; the fetched byte arrives in the latch
    always_comb begin
        next_s = cur;
        // reset sequence counter
        if (cur.rst_run) begin
            if (cur.rst_cnt == 16'(RESET_CYCLES - 1)) begin
                next_s.rst_run = 1'b0;
                next_s.rst_test[`RT_SW_RESET] = 1'b0;
            end else begin
                next_s.rst_cnt = cur.rst_cnt + 16'h0001;
            end
        end
        // software reset begins after the strobe ends
        if (cur.sw_pend && !write) begin
            next_s.sw_pend = 1'b0;
            next_s.rst_run = 1'b1;
            next_s.rst_cnt = 16'h0000;
            next_s.rst_test = `RT_RESET_VAL | 8'h80;
            next_s.parity_flag = 1'b0;
            next_s.test_on = 1'b0;
            next_s.ul = UL_IDLE;
            next_s.ba = BA_IDLE;
        end
        // buffer access engine
        case (cur.ba)
            BA_WAIT: begin
                if (mem_ack) begin
                    next_s.ba = BA_DONE;
                    if (!cur.ba_is_write) begin
                        next_s.latch = mem_rdata;
                    end
                    if (mem_parity_err && !cur.ba_is_write) begin
                        next_s.parity_flag = 1'b1;
                    end
                end
            end
            BA_DONE: begin
                next_s.ba = BA_IDLE;
                if (cur.ba_incr) begin
                    next_s.ptr = bump(cur.ptr, eff_test[`RT_CNT_TEST]);
                end
            end
            BA_IDLE: begin
            end
            default: next_s.ba = BA_IDLE;
        endcase
        // bus access
        if ((wr_hit || rd_hit) && !waitrequest) begin
            next_s.rdata = 32'h0000_0000;
            if (wr_hit && byteenable[0]) begin
                case (address)
                    `OFS_STATUS: begin
                        // write one clears; a same-cycle set still wins
                        if (wbyte[`ST_PARITY] && !(cur.ba == BA_WAIT && mem_ack && mem_parity_err)) begin
                            next_s.parity_flag = 1'b0;
                        end
                    end
                    `OFS_RESET_TEST: begin
                        if (wbyte[`RT_SW_RESET]) begin
                            next_s.sw_pend = 1'b1;
                        end else begin
                            next_s.rst_test = wbyte;
                            if (cur.ul == UL_ARMED && wbyte != 8'h00) begin
                                next_s.ul = UL_SET;
                            end else if (!cur.test_on) begin
                                next_s.ul = UL_IDLE;
                            end
                        end
                    end
                    `OFS_BUF_ACCESS, `OFS_BUF_AUTOINC: begin
                        next_s.latch = wbyte;
                        next_s.ba = BA_WAIT;
                        next_s.ba_is_write = 1'b1;
                        next_s.ba_incr = (address == `OFS_BUF_AUTOINC);
                    end
                    `OFS_DATA_LATCH: next_s.latch = wbyte;
                    `OFS_PTR_LO: next_s.ptr[7:0] = wbyte;
                    `OFS_PTR_MID: next_s.ptr[15:8] = wbyte;
                    `OFS_PTR_HI: next_s.ptr[PTR_W-1:16] = wbyte[PTR_W-17:0];
                    `OFS_TEST_VIEW: begin
                        next_s.tsel = wbyte;
                        case (cur.ul)
                            UL_IDLE: begin
                                if (wbyte == `UNLOCK_FIRST && (cur.rst_test & `RT_TEST_MASK) == 8'h00) begin
                                    next_s.ul = UL_ARMED;
                                end
                            end
                            UL_SET: begin
                                if (wbyte == `UNLOCK_SECOND) begin
                                    next_s.ul = UL_OPEN;
                                    next_s.test_on = 1'b1;
                                end else begin
                                    next_s.ul = UL_IDLE;
                                end
                            end
                            UL_ARMED: next_s.ul = (wbyte == `UNLOCK_FIRST) ? UL_ARMED : UL_IDLE;
                            default: begin
                            end
                        endcase
                    end
                    default: begin
                    end
                endcase
            end
            if (rd_hit) begin
                case (address)
                    `OFS_STATUS: next_s.rdata = {24'h000000, status_byte};
                    `OFS_BUF_ACCESS, `OFS_BUF_AUTOINC: begin
                        // returns fetched byte and starts the next fetch
                        next_s.rdata = {24'h000000, cur.latch};
                        next_s.ba = BA_WAIT;
                        next_s.ba_is_write = 1'b0;
                        next_s.ba_incr = (address == `OFS_BUF_AUTOINC);
                    end
                    `OFS_DATA_LATCH: next_s.rdata = {24'h000000, cur.latch};
                    `OFS_PTR_LO: next_s.rdata = {24'h000000, cur.ptr[7:0]};
                    `OFS_PTR_MID: next_s.rdata = {24'h000000, cur.ptr[15:8]};
                    `OFS_PTR_HI: next_s.rdata = {24'h000000, 4'h0, cur.ptr[PTR_W-1:16]};
                    `OFS_TEST_VIEW: begin
                        // select picks an internal view
                        case (cur.tsel[2:0])
                            3'h0: next_s.rdata = {24'h000000, cur.ptr[7:0]};
                            3'h1: next_s.rdata = {24'h000000, cur.ptr[15:8]};
                            3'h2: next_s.rdata = {24'h000000, 4'h0, cur.ptr[PTR_W-1:16]};
                            3'h3: next_s.rdata = {24'h000000, 2'b00, cur.ul, 2'b00, cur.ba};
                            3'h4: next_s.rdata = {24'h000000, cur.rst_test};
                            3'h5: next_s.rdata = {24'h000000, cur.rst_cnt[7:0]};
                            default: next_s.rdata = {24'h000000, test_probe};
                        endcase
                    end
                    default: next_s.rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    // the reset branch loads constants only; the power-up
    // sequence is started by setting its running flag here
    // the sequence counter starts at zero with the flag
    // channels stay in reset until the sequence ends
    always_ff @(posedge clock or negedge channel_a_reset_bit_n) begin
        if (!channel_a_reset_bit_n) begin
            cur <= '0;
            cur.rst_run <= 1'b1; // power-up sequence
            cur.ba <= BA_IDLE;
            cur.ul <= UL_IDLE;
        end else begin
            cur <= next_s;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // non-status registers stall during reset; buffer registers while busy
    // waitrequest depends only on registered state and the
    // request itself, so there is no loop through next state
    // the master must hold its request while this is high
    always_comb begin
        waitrequest = 1'b0;
        if (read || write) begin
            if (cur.rst_run && address != `OFS_STATUS) begin
                waitrequest = 1'b1;
            end else if (pending && (address == `OFS_BUF_ACCESS || address == `OFS_BUF_AUTOINC)) begin
                waitrequest = 1'b1;
            end
        end
    end
    // ----------------------------------------
    // output wiring
    // ----------------------------------------
    // read data is the view chosen for the accepted read, so it
    // stands at the accept edge; between accesses it shows the
    // last registered value, which is zero after an accepted write
    // memory side outputs come straight from state flops
    // test outputs are gated by the unlock, channel resets are
    // not: they work in normal mode and during the sequence
    assign readdata = next_s.rdata;
    assign mem_address = cur.ptr;
    assign mem_wdata = cur.latch;
    assign mem_write = cur.ba_is_write;
    assign mem_req = (cur.ba == BA_WAIT);
    assign route_fifo_a = eff_test[`RT_FIFO_A];
    assign route_fifo_b = eff_test[`RT_FIFO_B];
    assign counter_test = eff_test[`RT_CNT_TEST];
    assign mem_ctrl_oe_n = eff_test[`RT_MEM_FLOAT];
    assign channel_a_reset = cur.rst_test[`RT_CHAN_A] || cur.rst_run;
    assign channel_b_reset = cur.rst_test[`RT_CHAN_B] || cur.rst_run;
    assign full_reset = cur.rst_run;
endmodule
`default_nettype wire

// ### tb/bast_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module bast_mem_model (
    input wire logic clock, // clock
    input wire logic channel_a_reset_bit_n, // reset
    input wire logic mem_req, // request
    input wire logic mem_write, // write cycle
    input wire logic [19:0] mem_address, // address
    input wire logic [7:0] mem_wdata, // write data
    output logic mem_ack, // done pulse
    output logic [7:0] mem_rdata, // read data
    output logic mem_parity_err // parity error
);
    int lag = 1; // answer delay, set by bench
    logic perr = 1'b0; // inject parity error on reads
    logic [19:0] last_addr = 20'h0; // last address served
    logic [7:0] mem [256]; // low address byte only
    int cnt; // cycles waited
    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
    // idle data lines toggle so a stale byte never passes
    always @(posedge clock or negedge channel_a_reset_bit_n) begin
        if (!channel_a_reset_bit_n) begin
            mem_ack <= 1'b0;
            cnt <= 0;
            mem_rdata <= 8'h00;
            mem_parity_err <= 1'b0;
        end else if (mem_req && !mem_ack && cnt >= lag) begin
            mem_ack <= 1'b1;
            cnt <= 0;
            last_addr <= mem_address;
            mem_rdata <= mem[mem_address[7:0]];
            mem_parity_err <= perr && !mem_write;
            if (mem_write) mem[mem_address[7:0]] <= mem_wdata;
        end else begin
            mem_ack <= 1'b0;
            cnt <= mem_req ? cnt + 1 : 0;
            mem_rdata <= ~mem_rdata;
            mem_parity_err <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### tb/bast_props.sv
`timescale 1ns/1ps
`default_nettype none
module bast_props #(parameter int RESET_CYCLES = 16) (
    input wire logic clock, // clock
    input wire logic channel_a_reset_bit_n, // reset
    input wire logic [7:0] address, // bus address
    input wire logic read, // bus read
    input wire logic write, // bus write
    input wire logic [31:0] writedata, // bus data
    input wire logic waitrequest, // bus stall
    input wire logic mem_req, // buffer request
    input wire logic mem_ack, // buffer done
    input wire logic [19:0] mem_address, // buffer address
    input wire logic mem_write, // buffer direction
    input wire logic route_fifo_a, // fifo a path
    input wire logic route_fifo_b, // fifo b path
    input wire logic counter_test, // nibble mode
    input wire logic mem_ctrl_oe_n, // memory float
    input wire logic channel_a_reset, // channel a reset
    input wire logic channel_b_reset, // channel b reset
    input wire logic full_reset // sequence running
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!channel_a_reset_bit_n);
    // latch sits in the task file, so it never stalls once reset is over
    property p_latch_nowait;
        (read || write) && address == 8'hE8 && !full_reset |-> !waitrequest;
    endproperty
    a_latch_nowait: assert property (p_latch_nowait) else $error("latch access stalled");
    property p_req_hold;
        mem_req && !mem_ack |=> mem_req && $stable(mem_address) && $stable(mem_write);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("buffer cycle dropped");
    property p_req_drop;
        mem_ack |=> !mem_req;
    endproperty
    a_req_drop: assert property (p_req_drop) else $error("buffer cycle not ended");
    property p_reset_len;
        $fell(full_reset) |-> $past(full_reset, RESET_CYCLES - 1);
    endproperty
    a_reset_len: assert property (p_reset_len) else $error("reset sequence too short");
    property p_chan_in_reset;
        full_reset |-> channel_a_reset && channel_b_reset;
    endproperty
    a_chan_in_reset: assert property (p_chan_in_reset) else $error("channel out of reset");
    property p_test_off;
        full_reset |=> !(route_fifo_a || route_fifo_b || counter_test || mem_ctrl_oe_n);
    endproperty
    a_test_off: assert property (p_test_off) else $error("test mode kept in reset");
    property p_test_by_write;
        $rose(route_fifo_a || route_fifo_b || counter_test || mem_ctrl_oe_n)
            |-> $past(write) && ($past(address) == 8'hF8 || $past(address) == 8'h7A);
    endproperty
    a_test_by_write: assert property (p_test_by_write) else $error("test mode without write");
    property p_swreset;
        write && !waitrequest && address == 8'h7A && writedata[7] && !full_reset |-> ##[1:3] full_reset;
    endproperty
    a_swreset: assert property (p_swreset) else $error("software reset not started");
endmodule
bind buffer_access_status_test bast_props #(.RESET_CYCLES(RESET_CYCLES)) u_props (
    .clock, .channel_a_reset_bit_n, .address, .read, .write, .writedata, .waitrequest, .mem_req, .mem_ack,
    .mem_address, .mem_write, .route_fifo_a, .route_fifo_b, .counter_test, .mem_ctrl_oe_n,
    .channel_a_reset, .channel_b_reset, .full_reset);
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock = 0, channel_a_reset_bit_n = 0, read = 0, write = 0, pio_busy = 0; // driven inputs
    logic [7:0] address = 8'h00, q; // bus address, last read byte
    logic [31:0] writedata = 32'h0, readdata; // bus data
    logic waitrequest, mem_write, mem_req, mem_ack, mem_parity_err, full_reset;
    logic route_fifo_a, route_fifo_b, counter_test, mem_ctrl_oe_n, channel_a_reset, channel_b_reset;
    logic [19:0] mem_address; // buffer address
    logic [7:0] mem_wdata, mem_rdata; // buffer data
    int failures = 0, check_count = 0, cycles = 0;
    always #50 clock = ~clock; // 10 MHz
    // short reset sequence keeps the run brief
    buffer_access_status_test #(.RESET_CYCLES(6)) uut (.clock, .channel_a_reset_bit_n, .address, .read, .write,
        .writedata, .byteenable(4'hF), .readdata, .waitrequest, .mem_address, .mem_wdata, .mem_write,
        .mem_req, .mem_ack, .mem_rdata, .mem_parity_err, .route_fifo_a, .route_fifo_b, .counter_test,
        .mem_ctrl_oe_n, .channel_a_reset, .channel_b_reset, .full_reset, .pio_busy, .test_probe(8'h3C));
    bast_mem_model far (.clock, .channel_a_reset_bit_n, .mem_req, .mem_write, .mem_address, .mem_wdata, .mem_ack,
        .mem_rdata, .mem_parity_err);
    task automatic stop_test;
        if (failures == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures = failures + 1;
            stop_test;
        end
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    // one access; read data taken at the accept edge, one idle edge lets state settle
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        address <= a;
        write <= wr;
        read <= !wr;
        writedata <= {24'h0, d};
        do @(posedge clock); while (waitrequest !== 1'b0);
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clock);
    endtask
    function automatic logic [7:0] pins;
        return {2'h0, channel_b_reset, channel_a_reset, mem_ctrl_oe_n, counter_test, route_fifo_b, route_fifo_a};
    endfunction
    task automatic wait_idle;
        bus(0, 8'h64, 8'h00);
        while (q[7] !== 1'b0) bus(0, 8'h64, 8'h00);
    endtask
    task automatic set_ptr(input logic [19:0] p);
        bus(1, 8'hEC, p[7:0]);
        bus(1, 8'hEA, p[15:8]);
        bus(1, 8'hEE, {4'h0, p[19:16]});
    endtask
    task automatic unlock(input logic [7:0] bits);
        bus(1, 8'hF8, 8'h80);
        bus(1, 8'h7A, bits);
        bus(1, 8'hF8, 8'hF0);
    endtask
    task automatic t_reset;
        bus(0, 8'h64, 8'h00);
        chk("status in reset", 8'h90, q & 8'h90);
        bus(0, 8'hE8, 8'h00);
        bus(0, 8'h64, 8'h00);
        chk("ready after stall", 8'h00, q & 8'h80);
        wait_idle;
        chk("status idle", 8'h00, q);
        bus(1, 8'h7A, 8'h10);
        chk("chan a reset", 8'h10, pins());
        bus(1, 8'h7A, 8'h20);
        chk("chan b reset", 8'h20, pins());
        bus(1, 8'h7A, 8'h00);
    endtask
    task automatic t_pointer;
        set_ptr(20'h12345);
        bus(0, 8'hEE, 8'h00);
        chk("ptr top", 8'h01, q);
        bus(1, 8'h72, 8'h5A);
        wait_idle;
        chk("mem addr", 8'h45, far.last_addr[7:0]);
        chk("mem addr top", 8'h12, far.last_addr[19:12]);
        chk("mem byte", 8'h5A, far.mem[8'h45]);
        bus(0, 8'hEC, 8'h00);
        chk("ptr inc", 8'h46, q);
        bus(0, 8'hE8, 8'h00);
        chk("latch wr", 8'h5A, q);
    endtask
    task automatic t_parity;
        far.lag = 6;
        far.perr = 1'b1;
        bus(0, 8'h70, 8'h00);
        bus(0, 8'h64, 8'h00);
        chk("busy status", 8'h88, q & 8'h88);
        bus(0, 8'hE8, 8'h00);
        wait_idle;
        far.perr = 1'b0;
        far.lag = 1;
        chk("parity set", 8'h04, q & 8'h04);
        bus(0, 8'hE8, 8'h00);
        chk("latch rd", 8'hE3, q);
        bus(0, 8'hEC, 8'h00);
        chk("ptr kept", 8'h46, q);
        bus(1, 8'h64, 8'h00);
        bus(0, 8'h64, 8'h00);
        chk("parity kept", 8'h04, q & 8'h04);
        bus(1, 8'h64, 8'h04);
        bus(0, 8'h64, 8'h00);
        chk("parity clr", 8'h00, q);
    endtask
    task automatic t_test;
        pio_busy <= 1'b1;
        bus(0, 8'h64, 8'h00);
        chk("pio busy", 8'h80, q);
        pio_busy <= 1'b0;
        bus(1, 8'h7A, 8'h04);
        chk("locked", 8'h00, pins());
        bus(1, 8'h7A, 8'h00);
        unlock(8'h04);
        chk("cnt mode", 8'h04, pins());
        set_ptr(20'h12345);
        bus(1, 8'h72, 8'h11);
        wait_idle;
        bus(0, 8'hEA, 8'h00);
        chk("nibble mid", 8'h34, q);
        bus(1, 8'hF8, 8'h00);
        bus(0, 8'hF8, 8'h00);
        chk("view ptr", 8'h56, q);
        bus(1, 8'h7A, 8'h80);
        bus(0, 8'h64, 8'h00);
        chk("sw reset", 8'h90, q & 8'h90);
        wait_idle;
        chk("sw reset exit", 8'h00, pins());
        unlock(8'h0B);
        chk("fifo float", 8'h0B, pins());
        chk("fifo a path", 8'h01, pins() & 8'h01);
        channel_a_reset_bit_n <= 1'b0;
        @(posedge clock);
        channel_a_reset_bit_n <= 1'b1;
        @(posedge clock);
        chk("pin reset", 8'h30, pins());
        wait_idle;
        chk("pin reset exit", 8'h00, pins());
    endtask
    initial begin
        repeat (20) @(posedge clock);
        channel_a_reset_bit_n <= 1'b1;
        @(posedge clock);
        t_reset;
        t_pointer;
        t_parity;
        t_test;
        stop_test;
    end
endmodule
`default_nettype wire
